// ===== pfac_pkg.sv
/*
 * Shared constants and carriers for the pulse and fault control block.
 * Assumes a single 200 MHz system clock; all analog decisions arrive as
 * single-bit comparator levels.
 */
package pfac_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_FREQ_HZ      = 200_000_000;
    localparam int unsigned MASK_TIME_NS     = 220;  // spike_mask_time
    localparam int unsigned FAULT_BLANK_US   = 5;
    // Least times round up to whole cycles
    localparam int unsigned MASK_CYCLES      =
        (MASK_TIME_NS * (CLK_FREQ_HZ / 1_000_000) + 999) / 1000;
    localparam int unsigned FAULT_BLANK_CYC  =
        FAULT_BLANK_US * (CLK_FREQ_HZ / 1_000_000);

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic PULSE_RST = 1'b0;
    localparam logic FAULT_RST = 1'b0;
    localparam logic OV_EN_RST = 1'b1;

    // ------------------------------------------------------------------
    // Supply states, Gray coded along power-up, run, fault, power-down
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        PFAC_OFF   = 2'b00,
        PFAC_START = 2'b01,
        PFAC_RUN   = 2'b11,
        PFAC_FAULT = 2'b10
    } pfac_state_type;

    // ------------------------------------------------------------------
    // Comparator carrier
    // ------------------------------------------------------------------
    typedef struct packed {
        logic sense_amplifier;        // Amplified current above feedback
        logic slow_ramp_limit;        // Soft-start below feedback
        logic current_limit;          // Dynamic trip level exceeded
        logic overload_cmp;           // feedback_pin above 4.8 V
        logic ramp_done_cmp;          // slow_ramp_pin above 5.3 V
        logic ramp_ov_window_cmp;     // slow_ramp_pin above 4.0 V
        logic supply_overvoltage_cmp; // Supply above 16.5 V
        logic over_temp;              // Junction above 140 C
        logic supply_turn_on_level;   // Supply reached 13.5 V
        logic supply_turn_off_level;  // Supply below 8.5 V
        logic max_duty_end;           // Oscillator duty limit point
    } pfac_cmp_type;

endpackage : pfac_pkg

// ===== pfac_sync.sv
/*
 * Two-flop synchroniser for a vector of comparator levels.
 * Assumes inputs are levels; the first stage feeds only the second.
 */
`timescale 1ns/1ps
module pfac_sync
    import pfac_pkg::*;
#(
    parameter int WIDTH = 11
)(
    input  wire logic             clk_sys_i,
    input  wire logic             rst_i,
    input  wire logic [WIDTH-1:0] async_i,
    output logic      [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_reg;
    logic [WIDTH-1:0] sync_next;

    // Next values
    always_comb
    begin
        meta_next = async_i;
        sync_next = meta_reg;
    end

    // Registers
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            meta_reg <= '0;
            sync_reg <= '0;
        end
        else
        begin
            meta_reg <= meta_next;
            sync_reg <= sync_next;
        end
    end

    assign sync_o = sync_reg;

endmodule : pfac_sync

// ===== pfac_ctrl.sv
/*
 * Pulse latch, fault latch and auto-restart control of an off-line
 * current-mode converter controller.
 * Assumes analog comparators deliver levels and the oscillator a set
 * pulse; all are synchronised here to the 200 MHz system clock.
 */
//
// Contract
// - Ignore current limit for 220 ns after each turn-on
// - Current trip level falls with steeper slope (analog, delivered as input)
// - Oscillator pulse sets the pulse latch, starting conduction
// - Latch cleared by sense amp, soft-start, limit, overload or fault
// - Clearing the latch turns the gate drive off at once
// - Gate drive held low below supply turn-off level
// - Faults set the fault latch only after persisting 5 us
// - Overload detection disabled until slow ramp exceeds 5.3 V
// - After soft-start, feedback above 4.8 V sets the fault latch
// - With fault, stay off until 8.5 V, then discharge the slow ramp
// - At 13.5 V the power-up reset clears the fault, new soft-start
// - Overvoltage watch only in first soft-start, stops at 4.0 V and 4.8 V
// - Supply above 16.5 V during the watch sets the fault latch
// - Over-temperature sets the fault latch, entering auto-restart
// - Pulse ends at the oscillator's 0.72 duty limit point
// - Soft-start comparator clears the latch while ramp below feedback
`timescale 1ns/1ps
module pfac_ctrl
    import pfac_pkg::*;
#(
    parameter int MASK_CYC  = MASK_CYCLES,
    parameter int BLANK_CYC = FAULT_BLANK_CYC
)(
    input  wire logic         clk_sys_i,
    input  wire logic         rst_i,
    input  wire logic         osc_set_i,
    input  wire pfac_cmp_type cmp_i,
    output logic              gate_drive_o,
    output logic              ramp_discharge_switch_o,
    output logic              fault_latched_o,
    output logic              ov_watch_o,
    output logic              active_o
);

    // ------------------------------------------------------------------
    // Input synchronisation
    // ------------------------------------------------------------------
    localparam int NCMP = $bits(pfac_cmp_type);
    localparam int MW   = $clog2(MASK_CYC + 1);
    localparam int BW   = $clog2(BLANK_CYC + 1);

    logic [NCMP:0] sync_vec;
    pfac_cmp_type  cmp;
    logic          osc_set;

    // Comparator and oscillator levels into the clock domain
    pfac_sync #(
        .WIDTH (NCMP + 1)
    ) u_sync (
        .clk_sys_i (clk_sys_i),
        .rst_i     (rst_i),
        .async_i   ({osc_set_i, cmp_i}),
        .sync_o    (sync_vec)
    );

    assign cmp     = pfac_cmp_type'(sync_vec[NCMP-1:0]);
    assign osc_set = sync_vec[NCMP];

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    pfac_state_type state_reg,  state_next;
    logic           pulse_reg,  pulse_next;
    logic           fault_reg,  fault_next;
    logic           ov_en_reg,  ov_en_next;
    logic           osc_d_reg,  osc_d_next;
    logic [MW-1:0]  mask_reg,   mask_next;
    logic [BW-1:0]  blank_reg,  blank_next;

    logic osc_rise;
    logic fault_cond;
    logic reset_src;
    logic running;
    logic overload_and_gate;
    logic overvoltage_and_gate;

    // Protection decisions
    always_comb
    begin
        running  = (state_reg == PFAC_START) || (state_reg == PFAC_RUN);
        osc_rise = osc_set && !osc_d_reg;
        overload_and_gate    = cmp.ramp_done_cmp && cmp.overload_cmp;
        overvoltage_and_gate = ov_en_reg &&
                               cmp.supply_overvoltage_cmp;
        fault_cond = running && (overload_and_gate ||
                     overvoltage_and_gate || cmp.over_temp);
        reset_src  = cmp.sense_amplifier || cmp.slow_ramp_limit ||
                     (cmp.current_limit && (mask_reg == '0)) ||
                     cmp.overload_cmp || fault_reg ||
                     cmp.max_duty_end;
    end

    // Next values of supply state, latches and counters
    always_comb
    begin
        state_next = state_reg;
        pulse_next = pulse_reg;
        fault_next = fault_reg;
        ov_en_next = ov_en_reg;
        osc_d_next = osc_set;
        mask_next  = mask_reg;
        blank_next = blank_reg;

        // Supply lockout sequencing
        case (state_reg)
            PFAC_OFF:
            begin
                if (cmp.supply_turn_on_level && !cmp.supply_turn_off_level)
                begin
                    state_next = PFAC_START;
                    fault_next = 1'b0;
                end
            end
            PFAC_START:
            begin
                if (cmp.ramp_done_cmp)
                    state_next = PFAC_RUN;
            end
            PFAC_RUN:
            begin
                if (fault_reg)
                    state_next = PFAC_FAULT;
            end
            PFAC_FAULT:
            begin
                state_next = PFAC_FAULT;
            end
            default:
            begin
                state_next = PFAC_OFF;
            end
        endcase
        if (state_reg != PFAC_OFF && cmp.supply_turn_off_level)
            state_next = PFAC_OFF;
        else if (state_reg == PFAC_START && fault_reg)
            state_next = PFAC_FAULT;

        // Overvoltage watch closes for good once slow ramp exceeds 4.0 V with feedback above 4.8 V
        if (cmp.ramp_ov_window_cmp && cmp.overload_cmp)
            ov_en_next = 1'b0;

        // Fault blanking counter
        if (fault_cond && !fault_reg)
        begin
            if (blank_reg == BW'(BLANK_CYC - 1))
            begin
                fault_next = 1'b1;
                blank_next = '0;
            end
            else
                blank_next = blank_reg + 1'b1;
        end
        else
            blank_next = '0;

        // Pulse latch: low supply, inactivity and fault beat set; other clears act on a set latch only
        if (mask_reg != '0)
            mask_next = mask_reg - 1'b1;
        if (!running || cmp.supply_turn_off_level)
            pulse_next = 1'b0;
        else if (pulse_reg && reset_src)
            pulse_next = 1'b0;
        else if (osc_rise && !fault_reg)
        begin
            pulse_next = 1'b1;
            mask_next  = MW'(MASK_CYC);
        end
    end

    // Registers
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_reg <= PFAC_OFF;
            pulse_reg <= PULSE_RST;
            fault_reg <= FAULT_RST;
            ov_en_reg <= OV_EN_RST;
            osc_d_reg <= 1'b0;
            mask_reg  <= '0;
            blank_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            pulse_reg <= pulse_next;
            fault_reg <= fault_next;
            ov_en_reg <= ov_en_next;
            osc_d_reg <= osc_d_next;
            mask_reg  <= mask_next;
            blank_reg <= blank_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign gate_drive_o            = pulse_reg;
    assign ramp_discharge_switch_o = (state_reg == PFAC_OFF);
    assign fault_latched_o         = fault_reg;
    assign ov_watch_o              = ov_en_reg;
    assign active_o                = running;

endmodule : pfac_ctrl

// ===== pfac_ctrl_monitor.sv
/* Port checker of the pulse and fault control block.
   Assumes inputs reach the logic two cycles late. */
`timescale 1ns/1ps
module pfac_ctrl_monitor
    import pfac_pkg::*;
#(
    parameter int MASK_CYC  = MASK_CYCLES,
    parameter int BLANK_CYC = FAULT_BLANK_CYC
)(
    input wire logic         clk_sys_i,
    input wire logic         rst_i,
    input wire logic         osc_set_i,
    input wire pfac_cmp_type cmp_i,
    input wire logic         gate_drive_o,
    input wire logic         ramp_discharge_switch_o,
    input wire logic         fault_latched_o,
    input wire logic         ov_watch_o,
    input wire logic         active_o
);
    int   on_reg, on_next, flt_reg, flt_next;
    logic stop, halt, win;
    // On-time and standing fault counts
    always_comb
    begin
        stop = cmp_i.sense_amplifier || cmp_i.slow_ramp_limit ||
            cmp_i.overload_cmp || cmp_i.max_duty_end;
        halt = stop || cmp_i.supply_turn_off_level;
        win = cmp_i.ramp_ov_window_cmp && cmp_i.overload_cmp;
        on_next = gate_drive_o ? on_reg + 1 : 0;
        flt_next = (cmp_i.over_temp || cmp_i.supply_overvoltage_cmp ||
            cmp_i.overload_cmp && cmp_i.ramp_done_cmp) ? flt_reg + 1 : 0;
    end
    always_ff @(posedge clk_sys_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            on_reg  <= 0;
            flt_reg <= 0;
        end
        else
        begin
            on_reg  <= on_next;
            flt_reg <= flt_next;
        end
    end
    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (rst_i);
    sequence s_clear;
        stop[*3];
    endsequence
    sequence s_off;
        cmp_i.supply_turn_off_level[*3];
    endsequence
    property p_clear;
        s_clear |=> !gate_drive_o;
    endproperty
    property p_uvlo;
        s_off |=> !gate_drive_o && ramp_discharge_switch_o && !active_o;
    endproperty
    property p_set;
        $rose(gate_drive_o) |-> $past(osc_set_i, 3) && $past(active_o)
            && !$past(fault_latched_o);
    endproperty
    property p_mask;
        $fell(gate_drive_o) && on_reg < MASK_CYC - 4 |->
            $past(halt, 3) || $past(fault_latched_o);
    endproperty
    property p_blank;
        $rose(fault_latched_o) |-> flt_reg > BLANK_CYC;
    endproperty
    property p_hold;
        fault_latched_o ##1 fault_latched_o |-> !gate_drive_o;
    endproperty
    property p_pur;
        $fell(ramp_discharge_switch_o) |-> !fault_latched_o && active_o;
    endproperty
    property p_ovw;
        $fell(ov_watch_o) |-> $past(win, 3);
    endproperty
    a_clear: assert property (p_clear)
        else $error("gate on after clear");
    a_uvlo: assert property (p_uvlo)
        else $error("gate on at low supply");
    a_set: assert property (p_set)
        else $error("gate on without set");
    a_mask: assert property (p_mask)
        else $error("limit not masked");
    a_blank: assert property (p_blank)
        else $error("fault before blanking");
    a_hold: assert property (p_hold)
        else $error("gate on while faulted");
    a_pur: assert property (p_pur)
        else $error("fault kept at power up");
    a_ovw: assert property (p_ovw)
        else $error("watch closed early");
endmodule : pfac_ctrl_monitor
bind pfac_ctrl pfac_ctrl_monitor #(
    .MASK_CYC  (MASK_CYC),
    .BLANK_CYC (BLANK_CYC)
) i_mon (
    .clk_sys_i, .rst_i, .osc_set_i, .cmp_i, .gate_drive_o,
    .ramp_discharge_switch_o, .fault_latched_o, .ov_watch_o, .active_o
);

// ===== pfac_cmp_model.sv
/* Comparators, slow ramp and switch current around the block.
   Assumes levels in tenths of a volt from the bench. */
`timescale 1ns/1ps
module pfac_cmp_model
    import pfac_pkg::*;
(
    input  wire logic       clk_sys_i,
    input  wire logic       gate_i,
    input  wire logic       discharge_i,
    input  wire logic       active_i,
    input  wire logic       hot_i,
    input  wire logic [7:0] supply_i,
    input  wire logic [7:0] fb_i,
    input  wire logic [7:0] sense_len_i,
    input  wire logic [7:0] lim_len_i,
    input  wire logic [7:0] duty_len_i,
    output pfac_cmp_type    cmp_o
);
    int ramp = 0;
    int on_cnt = 0;
    // Ramp charges while active, on-time counts while gate high
    always @(posedge clk_sys_i)
    begin
        ramp <= discharge_i ? 0 : (active_i && ramp < 56) ? ramp + 1 : ramp;
        on_cnt <= gate_i ? on_cnt + 1 : 0;
    end
    // Comparator levels
    assign cmp_o = {gate_i && on_cnt >= sense_len_i,
                    ramp < fb_i,
                    gate_i && on_cnt >= lim_len_i,
                    fb_i > 8'h30, ramp > 53, ramp > 40,
                    supply_i > 8'ha5, hot_i, supply_i >= 8'h87,
                    supply_i < 8'h55, gate_i && on_cnt >= duty_len_i};
endmodule : pfac_cmp_model

// ===== test_pfac_ctrl.sv
/* Self-checking bench of the pulse and fault control block.
   Assumes the comparator model and the bound checker. */
`timescale 1ns/1ps
module test_pfac_ctrl;
    import pfac_pkg::*;
    localparam int BLANK = 10;
    logic clk_sys_i = 1'b0, rst_i = 1'b1, osc_set_i = 1'b0, hot = 1'b0;
    logic [7:0] sup = 8'h00, fb = 8'h14, sl = 8'hff, ll = 8'hff, dl = 8'hff;
    logic [31:0] rnd = 32'h0000_3457;
    logic gate, dis, flt, ovw, act;
    pfac_cmp_type cmp;
    int mismatches = 0, num_checks = 0, n, len, lo;
    pfac_ctrl #(.BLANK_CYC(BLANK)) i_dut (.clk_sys_i, .rst_i, .osc_set_i,
        .cmp_i(cmp), .gate_drive_o(gate), .ramp_discharge_switch_o(dis),
        .fault_latched_o(flt), .ov_watch_o(ovw), .active_o(act));
    pfac_cmp_model i_far (.clk_sys_i, .gate_i(gate), .discharge_i(dis),
        .active_i(act), .hot_i(hot), .supply_i(sup), .fb_i(fb),
        .sense_len_i(sl), .lim_len_i(ll), .duty_len_i(dl), .cmp_o(cmp));
    initial
    begin
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction : xs
    task automatic check(string nm, logic [7:0] seen, logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("[FAIL] %s exp %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic complete_run;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : complete_run
    // Bounded wait for gate, fault or active to reach a level
    task automatic wait_on(int sel, logic v, int lim);
        for (n = 0; (sel == 0 ? gate : sel == 1 ? flt : act) !== v; n++)
        begin
            if (n == lim)
            begin
                check("wait", 8'h00, 8'h01);
                complete_run();
            end
            @(negedge clk_sys_i);
        end
    endtask : wait_on
    // One oscillator set, then measure the on-time
    task automatic pulse;
        @(negedge clk_sys_i) osc_set_i = 1'b1;
        @(negedge clk_sys_i) osc_set_i = 1'b0;
        len = 0;
        repeat (3) @(negedge clk_sys_i);
        for (len = 0; gate === 1'b1 && len < 300; len++)
            @(negedge clk_sys_i);
    endtask : pulse
    task automatic power_up;
        sup = 8'h8c;
        wait_on(2, 1'b1, 20);
        check("fault", flt, 8'h00);
        repeat (70) @(negedge clk_sys_i);
    endtask : power_up
    initial
    begin
        repeat (6) @(negedge clk_sys_i);
        check("reset", {gate, dis, flt, ovw, act}, 8'h0a);
        rst_i = 1'b0;
        power_up();
        for (int i = 0; i < 9; i++)
        begin
            rnd = xs(rnd);
            case (i % 3)
                0: sl = 8'h01 + rnd[3:0];
                1: ll = 8'h01 + rnd[3:0];
                default: dl = 8'h32 + rnd[3:0];
            endcase
            lo = (i % 3 == 1) ? MASK_CYCLES : (sl < dl ? sl : dl);
            pulse();
            check("on_time", len >= lo - 2 && len <= lo + 5, 8'h01);
            {sl, ll, dl} = 24'hff_ffff;
        end
        dl = 8'h64;
        pulse();
        sup = 8'h50;
        repeat (4) @(negedge clk_sys_i);
        check("uvlo", {gate, dis, act}, 8'h02);
        power_up();
        fb = 8'h32;
        wait_on(1, 1'b1, BLANK + 20);
        check("blank", n >= BLANK, 8'h01);
        check("watch", ovw, 8'h00);
        pulse();
        check("held", len, 8'h00);
        sup = 8'h50;
        wait_on(2, 1'b0, 10);
        // Faulted state is already inactive; let the lockout reach OFF
        repeat (4) @(negedge clk_sys_i);
        check("discharge", dis, 8'h01);
        fb = 8'h14;
        power_up();
        hot = 1'b1;
        wait_on(1, 1'b1, BLANK + 20);
        hot = 1'b0;
        rst_i = 1'b1;
        repeat (6) @(negedge clk_sys_i);
        rst_i = 1'b0;
        check("watch", ovw, 8'h01);
        sup = 8'haa;
        wait_on(1, 1'b1, BLANK + 40);
        complete_run();
    end
endmodule : test_pfac_ctrl
